/* rtl/floppy_drive_interface.sv */
// Purpose: Drive-side interface: status gating, head positioner, spindle and write checks.
// Assumes: Cable inputs are asynchronous; all but spindle_request_b pass a two-flop synchroniser here.
// Notes:   Index is open collector; index_oe_b low pulls the line low.
//
// Implementation choices: the address-and-strobe port and the register offsets.
`timescale 1ns/100ps

module floppy_drive_interface
  import floppy_pkg::*;
#(
  parameter int unsigned SPIN_CYCLES = SPINUP_CYC,
  parameter int unsigned REV_CYCLES = REV_CYC,
  parameter int unsigned INDEX_CYCLES = INDEX_CYC,
  parameter int unsigned STEP_CYCLES = STEP_CYC
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Controller inputs, active low unless noted
  input wire logic unit_choice_0_b,
  input wire logic unit_choice_1_b,
  input wire logic spindle_request_b,
  input wire logic step_b,
  input wire logic direction,
  input wire logic head_engage_b,
  input wire logic record_enable_b,
  input wire logic write_data_b,
  // Controller outputs
  output logic ready_b,
  output logic media_lock_b,
  output logic at_home_b,
  output logic index_oe_b,
  output logic read_data_b,
  // Drive sensors and media stream
  input wire logic disk_present,
  input wire logic disk_protected,
  input wire logic media_stream,
  // Drive actuators
  output logic spindle_run,
  output logic head_load,
  output logic activity_led,
  output logic write_circuit_en,
  output logic erase_en,
  output logic head_current,
  output logic stepper_pulse,
  output logic stepper_inward
);

  // ==========================================================================
  // Helpers
  // One track toward either end, clamped at the ends
  function automatic logic [6:0] step_track(input logic [6:0] cur, input logic inward);
    logic [6:0] res;
    res = cur;
    if (inward && cur < TRACK_MAX) begin
      res = cur + 7'h01;
    end else if (!inward && cur > TRACK_MIN) begin
      res = cur - 7'h01;
    end
    return res;
  endfunction

  // ==========================================================================
  // Input synchronisers
  // Stage one is read only by stage two; a third stage gives the step edge
  logic [6:0] sync_a;
  logic [6:0] sync_b;
  logic step_prev;
  logic wdata_prev;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sync_a <= 7'h7f;
      sync_b <= 7'h7f;
      step_prev <= 1'b1;
      wdata_prev <= 1'b1;
    end else begin
      sync_a <= {write_data_b, record_enable_b, head_engage_b, direction, step_b,
                 unit_choice_1_b, unit_choice_0_b};
      sync_b <= sync_a;
      step_prev <= sync_b[2];
      wdata_prev <= sync_b[6];
    end
  end

  wire choice0_s = !sync_b[0];
  wire choice1_s = !sync_b[1];
  wire step_s_b = sync_b[2];
  wire direction_s = sync_b[3];
  wire engage_s = !sync_b[4];
  wire rec_en_s = !sync_b[5];
  wire wdata_s_b = sync_b[6];
  wire step_fall = step_prev && !step_s_b;
  wire wdata_fall = wdata_prev && !wdata_s_b;

  // ==========================================================================
  // Register file
  logic [1:0] ctrl;
  wire unit_number = ctrl[CTRL_UNIT_BIT];
  wire free_run = ctrl[CTRL_FREE_RUN_BIT];
  wire sel_s = unit_number ? choice1_s : choice0_s;

  // Control register write
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl <= CTRL_RESET;
    end else if (reg_wr && reg_addr == CTRL_OFFSET) begin
      ctrl <= reg_wdata[1:0];
    end
  end

  // ==========================================================================
  // Spindle
  // Free-run mode spins with no disk; default spins only with a disk
  logic [31:0] spin_cnt;
  logic at_speed;
  wire next_run = !spindle_request_b && (disk_present || free_run);
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      spindle_run <= 1'b0;
      spin_cnt <= 32'h0;
      at_speed <= 1'b0;
    end else begin
      spindle_run <= next_run;
      if (!next_run) begin
        spin_cnt <= 32'h0;
        at_speed <= 1'b0;
      end else if (spin_cnt >= SPIN_CYCLES - 1) begin
        at_speed <= 1'b1;
      end else begin
        spin_cnt <= spin_cnt + 32'h1;
      end
    end
  end

  // ==========================================================================
  // Revolution timer and index
  logic [31:0] rev_cnt;
  wire index_active = at_speed && (rev_cnt < INDEX_CYCLES);
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rev_cnt <= 32'h0;
    end else if (!at_speed || rev_cnt >= REV_CYCLES - 1) begin
      rev_cnt <= 32'h0;
    end else begin
      rev_cnt <= rev_cnt + 32'h1;
    end
  end

  // ==========================================================================
  // Ready delay
  // Drops at once when any condition fails, rises after the delay
  logic [7:0] ready_cnt;
  wire ready_cond = sel_s && disk_present && at_speed;
  wire ready_due = ready_cond && ready_cnt >= 8'(READY_CYC - 1);
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ready_cnt <= 8'h0;
    end else if (!ready_cond) begin
      ready_cnt <= 8'h0;
    end else if (!ready_due) begin
      ready_cnt <= ready_cnt + 8'h1;
    end
  end

  // ==========================================================================
  // Head positioner
  // Host steps are ignored while the power-up seek runs
  pos_state_type pos_state;
  logic [6:0] track;
  logic [31:0] settle_cnt;
  wire host_step = step_fall && sel_s && pos_state != POS_HOMING;
  wire host_inward = !direction_s;
  wire home_step = pos_state == POS_HOMING && settle_cnt == 32'h0 && track != TRACK_MIN;
  wire step_move = host_step && step_track(track, host_inward) != track;
  wire stationary = pos_state == POS_IDLE;

  // Track counter and state
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pos_state <= POS_HOMING;
      track <= TRACK_RESET;
      settle_cnt <= 32'h0;
    end else begin
      case (pos_state)
        POS_HOMING: begin
          if (track == TRACK_MIN && settle_cnt == 32'h0) begin
            pos_state <= POS_IDLE;
          end else if (home_step) begin
            track <= step_track(track, 1'b0);
            settle_cnt <= STEP_CYCLES - 1;
          end else if (settle_cnt != 32'h0) begin
            settle_cnt <= settle_cnt - 32'h1;
          end
        end
        POS_IDLE, POS_SETTLE: begin
          if (step_move) begin
            track <= step_track(track, host_inward);
            settle_cnt <= STEP_CYCLES - 1;
            pos_state <= POS_SETTLE;
          end else if (settle_cnt != 32'h0) begin
            settle_cnt <= settle_cnt - 32'h1;
          end else begin
            pos_state <= POS_IDLE;
          end
        end
        default: begin
          pos_state <= POS_HOMING;
        end
      endcase
    end
  end

  // ==========================================================================
  // Head load and write path
  // Engage needs selection to start, but not to stay loaded
  wire next_loaded = engage_s && (sel_s || head_load);
  wire write_ok = sel_s && rec_en_s && !disk_protected && at_speed && head_load && stationary;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      head_load <= 1'b0;
      activity_led <= 1'b0;
      write_circuit_en <= 1'b0;
      erase_en <= 1'b0;
      head_current <= 1'b0;
    end else begin
      head_load <= next_loaded;
      activity_led <= next_loaded;
      write_circuit_en <= rec_en_s;
      erase_en <= rec_en_s;
      if (wdata_fall && write_ok) begin
        head_current <= !head_current;
      end
    end
  end

  // ==========================================================================
  // Cable outputs and stepper drive
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ready_b <= 1'b1;
      media_lock_b <= 1'b1;
      at_home_b <= 1'b1;
      index_oe_b <= 1'b1;
      read_data_b <= 1'b1;
      stepper_pulse <= 1'b0;
      stepper_inward <= 1'b0;
    end else begin
      ready_b <= !ready_due;
      media_lock_b <= !(sel_s && disk_present && disk_protected);
      at_home_b <= !(sel_s && track == TRACK_MIN);
      index_oe_b <= !(sel_s && index_active);
      read_data_b <= sel_s ? media_stream : 1'b1;
      stepper_pulse <= step_move || home_step;
      stepper_inward <= step_move && host_inward;
    end
  end

  // ==========================================================================
  // Register read
  // Data stand only in the cycle after the strobe; unmapped reads zero
  wire [31:0] status_word = {18'h0, pos_state == POS_SETTLE, pos_state == POS_HOMING, write_ok,
                             head_load, !ready_b, at_speed, 1'b0, track};
  wire [31:0] read_mux = (reg_addr == CTRL_OFFSET) ? {30'h0, ctrl} :
                         (reg_addr == STATUS_OFFSET) ? status_word : 32'h0;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 32'h0;
    end else begin
      reg_rdata <= reg_rd ? read_mux : 32'h0;
    end
  end

  // ==========================================================================
  // Checks
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);

  sequence cond_rises;
    $rose(ready_cond) ##1 ready_cond [*8];
  endsequence

  sequence valid_inward;
    host_step && host_inward && track < TRACK_MAX;
  endsequence

  a_ready_needs_cond: assert property (!ready_b |-> $past(ready_cond))
    else $error("ready asserted without its conditions");
  a_ready_not_early: assert property (cond_rises |-> ready_b)
    else $error("ready asserted before the selection delay");
  a_lock_deselect: assert property (!sel_s |=> media_lock_b)
    else $error("write protect low while deselected");
  a_index_deselect: assert property (!sel_s |=> index_oe_b)
    else $error("index pulled low while deselected");
  a_home_deselect: assert property (!sel_s |=> at_home_b)
    else $error("track zero low while deselected");
  a_read_deselect: assert property (!sel_s |=> read_data_b)
    else $error("read data not high while deselected");
  a_step_inward: assert property (valid_inward |=> track == $past(track) + 7'h01)
    else $error("inward step did not move one track");
  a_step_clamp: assert property (host_step && !host_inward && track == TRACK_MIN |=> track == TRACK_MIN)
    else $error("step below track zero moved the head");
  a_track_range: assert property (track <= TRACK_MAX)
    else $error("track beyond last track");
  a_head_keep: assert property (head_load && engage_s |=> head_load)
    else $error("engaged head released");
  a_write_flip: assert property (head_current != $past(head_current) |-> $past(write_ok && wdata_fall))
    else $error("head current flipped without write conditions");
  a_spin_stop: assert property (!disk_present && !free_run |=> !spindle_run)
    else $error("spindle running without a disk");

endmodule // floppy_drive_interface

/* rtl/floppy_pkg.sv */
// Purpose: Shared constants for the drive-side floppy interface logic.
// Assumes: 100 MHz system clock, times given in their own units.
// Notes:   Long counts feed module parameters so simulations can shorten them.
package floppy_pkg;

  // ==========================================================================
  // Clock and timing
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned READY_DELAY_NS = 500;
  localparam int unsigned READY_CYC = (READY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam longint unsigned SPINUP_MS = 1000;
  localparam int unsigned SPINUP_CYC = int'((SPINUP_MS * 64'd1000000) / CLK_PERIOD_NS);
  localparam longint unsigned REV_MS = 100;
  localparam int unsigned REV_CYC = int'((REV_MS * 64'd1000000) / CLK_PERIOD_NS);
  localparam int unsigned INDEX_MIN_US = 150;
  localparam int unsigned INDEX_MAX_US = 350;
  localparam int unsigned INDEX_US = (INDEX_MIN_US + INDEX_MAX_US) / 2;
  localparam int unsigned INDEX_CYC = (INDEX_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned STEP_MS = 15;
  localparam int unsigned STEP_CYC = (STEP_MS * 1000000) / CLK_PERIOD_NS;

  // ==========================================================================
  // Track geometry
  localparam logic [6:0] TRACK_MIN = 7'h00;
  localparam logic [6:0] TRACK_MAX = 7'h45;
  localparam logic [6:0] TRACK_RESET = 7'h45;

  // ==========================================================================
  // Register map
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam int unsigned CTRL_UNIT_BIT = 0;
  localparam int unsigned CTRL_FREE_RUN_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam int unsigned STAT_TRACK_LSB = 0;
  localparam int unsigned STAT_SPEED_BIT = 8;
  localparam int unsigned STAT_READY_BIT = 9;
  localparam int unsigned STAT_LOADED_BIT = 10;
  localparam int unsigned STAT_WRITE_BIT = 11;
  localparam int unsigned STAT_HOMING_BIT = 12;
  localparam int unsigned STAT_MOVING_BIT = 13;

  // ==========================================================================
  // Head positioner states
  typedef enum logic [2:0] {
    POS_HOMING = 3'b001,
    POS_IDLE = 3'b010,
    POS_SETTLE = 3'b100
  } pos_state_type;

endpackage

/* tb/floppy_ctrl_model.sv */
// Purpose: Controller-side model that drives the drive cable lines.
// Assumes: Every change follows a rising edge of sys_clk.
// Notes:   The bench calls its tasks and sets its lines by hierarchical name.
`timescale 1ns/100ps
module floppy_ctrl_model (
  // Clock
  input wire logic sys_clk,
  // Cable lines toward the drive
  output logic unit_choice_0_b,
  output logic unit_choice_1_b,
  output logic spindle_request_b,
  output logic step_b,
  output logic direction,
  output logic head_engage_b,
  output logic record_enable_b,
  output logic write_data_b
);
  // ==========================================================================
  // Idle cable at time zero, except spindle request held asserted
  initial begin
    unit_choice_0_b = 1'b1;
    unit_choice_1_b = 1'b1;
    spindle_request_b = 1'b0;
    step_b = 1'b1;
    direction = 1'b0;
    head_engage_b = 1'b1;
    record_enable_b = 1'b1;
    write_data_b = 1'b1;
  end
  // Step pulse 3 low, 3 high; shorter pulses can slip past the synchroniser
  task automatic step(input logic dir);
    direction <= dir;
    record_enable_b <= 1'b1;
    @(posedge sys_clk);
    step_b <= 1'b0;
    repeat (3) @(posedge sys_clk);
    step_b <= 1'b1;
    repeat (3) @(posedge sys_clk);
  endtask
  // One falling edge of write data
  task automatic wr_edge();
    write_data_b <= 1'b0;
    repeat (3) @(posedge sys_clk);
    write_data_b <= 1'b1;
    repeat (3) @(posedge sys_clk);
  endtask
endmodule // floppy_ctrl_model

/* tb/testbench.sv */
// Purpose: Self-checking bench for the drive-side floppy interface.
// Assumes: Shortened spin, revolution, index and settle counts.
// Notes:   Scenarios run in order; head position carries over between them.
`timescale 1ns/100ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin num_errors++; $display("mismatch at %0t got %h exp %h", $time, g, e); end end
module testbench;
  import floppy_pkg::*;
  localparam int unsigned SPIN = 100;
  localparam int unsigned REV = 400;
  localparam int unsigned IDX = 20;
  localparam int unsigned STP = 8;
  // ==========================================================================
  // Stimulus and observed lines
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic disk_present = 1'b0;
  logic disk_protected = 1'b0;
  logic media_stream = 1'b1;
  logic [31:0] reg_rdata, rd;
  logic unit_choice_0_b, unit_choice_1_b, spindle_request_b, step_b, direction;
  logic head_engage_b, record_enable_b, write_data_b, h;
  logic ready_b, media_lock_b, at_home_b, index_oe_b, read_data_b, spindle_run, head_load;
  logic activity_led, write_circuit_en, erase_en, head_current, stepper_pulse, stepper_inward;
  int num_errors = 0;
  int n_tests = 0;
  int n_in = 0;
  int n_out = 0;
  int w, k;

  floppy_ctrl_model ctl (.sys_clk, .unit_choice_0_b, .unit_choice_1_b, .spindle_request_b,
    .step_b, .direction, .head_engage_b, .record_enable_b, .write_data_b);
  floppy_drive_interface #(.SPIN_CYCLES(SPIN), .REV_CYCLES(REV), .INDEX_CYCLES(IDX),
    .STEP_CYCLES(STP)) dut (.sys_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .unit_choice_0_b, .unit_choice_1_b, .spindle_request_b, .step_b, .direction,
    .head_engage_b, .record_enable_b, .write_data_b, .ready_b, .media_lock_b, .at_home_b,
    .index_oe_b, .read_data_b, .disk_present, .disk_protected, .media_stream, .spindle_run,
    .head_load, .activity_led, .write_circuit_en, .erase_en, .head_current, .stepper_pulse,
    .stepper_inward);

  // Clock and a run-length guard against hangs
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    #(100000 * 10);
    tmo(1'b0);
  end
  // Count real head moves by direction
  always @(posedge sys_clk) begin
    if (stepper_pulse === 1'b1 && stepper_inward === 1'b1) n_in++;
    if (stepper_pulse === 1'b1 && stepper_inward === 1'b0) n_out++;
  end

  task automatic end_sim();
    $display("errors %0d checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // An expired wait counts as a mismatch and ends the run
  task automatic tmo(input bit ok);
    if (!ok) begin
      num_errors++;
      $display("mismatch at %0t got %h exp %h", $time, 1'b0, 1'b1);
      end_sim();
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic sel(input bit on);
    ctl.unit_choice_0_b <= !on;
    tick(6);
  endtask
  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    d = reg_rdata;
    @(posedge sys_clk);
  endtask

  // Homing after reset, then unit selection through the control register
  task automatic t_home();
    sel(1);
    for (int i = 0; i < 69 * STP + 200 && at_home_b !== 1'b0; i++) @(posedge sys_clk);
    tmo(at_home_b === 1'b0);
    `CHK(n_out, 69)
    reg_read(STATUS_OFFSET, rd);
    `CHK(rd[6:0], TRACK_MIN)
    sel(0);
    ctl.unit_choice_1_b <= 1'b0;
    tick(6);
    `CHK(at_home_b, 1'b1)
    reg_write(CTRL_OFFSET, 32'h1);
    tick(6);
    `CHK(at_home_b, 1'b0)
    reg_read(8'h08, rd);
    `CHK(rd, 32'h0)
    reg_write(CTRL_OFFSET, 32'h0);
    ctl.unit_choice_1_b <= 1'b1;
    sel(1);
  endtask
  // Ready after insertion, after selection, and drop on removal
  task automatic t_ready();
    disk_present <= 1'b1;
    tick(SPIN / 2);
    `CHK(ready_b, 1'b1)
    for (int i = 0; i < SPIN + 80 && ready_b !== 1'b0; i++) @(posedge sys_clk);
    tmo(ready_b === 1'b0);
    `CHK(spindle_run, 1'b1)
    sel(0);
    `CHK(ready_b, 1'b1)
    sel(1);
    tick(READY_CYC - 16);
    `CHK(ready_b, 1'b1)
    for (k = 0; k < 30 && ready_b !== 1'b0; k++) @(posedge sys_clk);
    tmo(ready_b === 1'b0);
    disk_present <= 1'b0;
    tick(5);
    `CHK({spindle_run, ready_b}, 2'b01)
    disk_present <= 1'b1;
    for (int i = 0; i < SPIN + 80 && ready_b !== 1'b0; i++) @(posedge sys_clk);
    tmo(ready_b === 1'b0);
  endtask
  // Status lines follow selection only
  task automatic t_gate();
    disk_protected <= 1'b1;
    media_stream <= 1'b0;
    tick(6);
    `CHK({media_lock_b, at_home_b, read_data_b}, 3'b000)
    sel(0);
    `CHK({media_lock_b, at_home_b, read_data_b}, 3'b111)
    w = 0;
    for (int i = 0; i < REV + IDX; i++) begin
      @(posedge sys_clk);
      if (index_oe_b !== 1'b1) w++;
    end
    `CHK(w, 0)
    disk_protected <= 1'b0;
    media_stream <= 1'b1;
    sel(1);
  endtask
  // Index width and period in cycles
  task automatic t_index();
    for (int i = 0; i < REV + 10 && index_oe_b !== 1'b0; i++) @(posedge sys_clk);
    tmo(index_oe_b === 1'b0);
    for (w = 0; w < REV && index_oe_b === 1'b0; w++) @(posedge sys_clk);
    for (k = 0; k < REV && index_oe_b === 1'b1; k++) @(posedge sys_clk);
    `CHK(w, IDX)
    `CHK(w + k, REV)
  endtask
  // Steps: both ends of the track range, direction, deselected pulses
  task automatic t_step();
    ctl.step(1'b1);
    `CHK(n_out, 69)
    for (int i = 0; i < 3; i++) ctl.step(1'b0);
    `CHK(n_in, 3)
    `CHK(at_home_b, 1'b1)
    sel(0);
    ctl.step(1'b0);
    `CHK(n_in, 3)
    sel(1);
    ctl.step(1'b1);
    reg_read(STATUS_OFFSET, rd);
    `CHK(rd[6:0], 7'h02)
    for (int i = 0; i < 68; i++) ctl.step(1'b0);
    reg_read(STATUS_OFFSET, rd);
    `CHK(rd[6:0], TRACK_MAX)
    `CHK(n_in, 70)
    tick(STP + 4);
  endtask
  // Head load, then write gating and current flips
  task automatic t_write();
    ctl.head_engage_b <= 1'b0;
    tick(6);
    `CHK({head_load, activity_led}, 2'b11)
    sel(0);
    `CHK({head_load, activity_led}, 2'b11)
    sel(1);
    ctl.record_enable_b <= 1'b0;
    tick(6);
    `CHK({write_circuit_en, erase_en}, 2'b11)
    h = head_current;
    ctl.wr_edge();
    `CHK(head_current, ~h)
    disk_protected <= 1'b1;
    tick(6);
    ctl.wr_edge();
    `CHK(head_current, ~h)
    disk_protected <= 1'b0;
    sel(0);
    ctl.wr_edge();
    `CHK(head_current, ~h)
    sel(1);
    ctl.record_enable_b <= 1'b1;
    ctl.head_engage_b <= 1'b1;
    tick(6);
    `CHK({write_circuit_en, head_load}, 2'b00)
  endtask

  // Main sequence
  initial begin
    tick(8);
    `CHK({ready_b, media_lock_b, at_home_b, index_oe_b, read_data_b, spindle_run}, 6'h3e)
    rst_b <= 1'b1;
    t_home();
    t_ready();
    t_gate();
    t_index();
    t_step();
    t_write();
    end_sim();
  end
endmodule // testbench
